// ===== core/rsi_map.vh
// Constants for the reset and interrupt sequencer
`ifndef RSI_MAP_VH
`define RSI_MAP_VH
`define RSI_CLK_HZ        10000000
`define RSI_POR_US        1000
`define RSI_POR_CYC       ((`RSI_POR_US * (`RSI_CLK_HZ / 1000000)))
`define RSI_ENTRY_CYC     11
`define RSI_OPT_CLK_BIT   7
`define RSI_OPT_ADDR      11'h784
`define RSI_VEC_RESET     11'h7fe
`define RSI_VEC_TRAP      11'h7fc
`define RSI_VEC_EXT       11'h7fa
`define RSI_VEC_TIMER     11'h7f8
`define RSI_SRC_NONE      2'h0
`define RSI_SRC_EXT       2'h1
`define RSI_SRC_TIMER     2'h2
`define RSI_SRC_TRAP      2'h3
`endif

// ===== core/rsi_sync_edge.v
// Two-flop synchroniser with re-arming falling-edge detector
`timescale 1ns/1ps
module rsi_sync_edge (
    // Clock and reset
    input  wire sys_clk,
    input  wire rst_n,
    // Pin side
    input  wire pinIn,
    // Synchronised level and falling-edge pulse
    output wire levelOut,
    output wire fallPulse
);
    reg metaQ;
    reg syncQ;
    reg armedQ;

    // Armed only once a high level is seen, so a stuck-low line fires once
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            metaQ  <= 1'b1;
            syncQ  <= 1'b1;
            armedQ <= 1'b0;
        end else begin
            metaQ  <= pinIn;
            syncQ  <= metaQ;
            if (syncQ)
                armedQ <= 1'b1;
            else
                armedQ <= 1'b0;
        end
    end

    assign levelOut  = syncQ;
    assign fallPulse = armedQ & ~syncQ;
endmodule // rsi_sync_edge

// ===== core/rsi_por_timer.v
// Power-on delay counter that holds reset while the clock settles
`timescale 1ns/1ps
module rsi_por_timer #(
    parameter CYCLES = 10000
) (
    // Clock and reset
    input  wire sys_clk,
    input  wire rst_n,
    // Restart request from low-voltage recovery
    input  wire restart,
    // High while the delay runs
    output wire holding
);
    reg [31:0] cntQ;

    always @(posedge sys_clk) begin
        if (!rst_n || restart)
            cntQ <= 32'h0;
        else if (cntQ < CYCLES)
            cntQ <= cntQ + 32'h1;
    end

    assign holding = (cntQ < CYCLES);
endmodule // rsi_por_timer

// ===== core/rsi_reset_irq.v
// Reset sequencing and interrupt arbitration for the machine-cycle core
`timescale 1ns/1ps
`include "rsi_map.vh"
module rsi_reset_irq #(
    parameter POR_CYCLES = `RSI_POR_CYC,
    parameter HAS_LVD    = 1
) (
    // Clock and power-up reset
    input  wire        sys_clk,
    input  wire        rst_n,
    // External reset line, open-drain
    input  wire        resetLineIn,
    output wire        resetLineOut,
    output wire        resetLineOe_n,
    // Low-voltage detector, asynchronous
    input  wire        lowVoltage,
    // Timer pin at bootstrap level, asynchronous
    input  wire        bootstrapLevel,
    // Option byte fetch
    output reg         optReadReq,
    output reg  [10:0] optAddr,
    input  wire [7:0]  optData,
    input  wire        optValid,
    output reg         rcOscSel,
    output reg  [7:0]  optionByte,
    // Interrupt sources
    input  wire        extReq_n,
    input  wire        timerReq,
    // Processor handshake
    input  wire        instrDone,
    input  wire        trapExec,
    input  wire        returnExec,
    input  wire        maskBit,
    output reg         coreReset,
    output reg         entryBusy,
    output reg         stackPush,
    output reg         stackPop,
    output reg         setMask,
    output reg  [10:0] vectorAddr,
    output reg         vectorLoad,
    output reg  [1:0]  entrySource,
    output reg         extPending,
    output reg         timerPending
);
    localparam [3:0] ST_RESET = 4'b0001;
    localparam [3:0] ST_OPT   = 4'b0010;
    localparam [3:0] ST_RUN   = 4'b0100;
    localparam [3:0] ST_ENTRY = 4'b1000;

    // Synchronised inputs
    wire resetLevel;
    wire extFall;
    reg  lvdMetaQ;
    reg  lvdSyncQ;
    reg  bootMetaQ;
    reg  bootSyncQ;
    reg  timerArmedQ;
    wire porHold;
    wire lvdActive;
    wire timerEdge;

    rsi_sync_edge uResetSync (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .pinIn     (resetLineIn),
        .levelOut  (resetLevel),
        .fallPulse ()
    );

    rsi_sync_edge uExtSync (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .pinIn     (extReq_n),
        .levelOut  (),
        .fallPulse (extFall)
    );

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            lvdMetaQ    <= 1'b0;
            lvdSyncQ    <= 1'b0;
            bootMetaQ   <= 1'b0;
            bootSyncQ   <= 1'b0;
            timerArmedQ <= 1'b0;
        end else begin
            lvdMetaQ    <= lowVoltage;
            lvdSyncQ    <= lvdMetaQ;
            bootMetaQ   <= bootstrapLevel;
            bootSyncQ   <= bootMetaQ;
            timerArmedQ <= ~timerReq;
        end
    end

    // Two flops only delay the low-supply level by two cycles; a pulse seen at one edge is enough
    assign lvdActive = (HAS_LVD != 0) && lvdSyncQ;
    assign timerEdge = timerArmedQ & timerReq;

    // Recovery from low voltage restarts the power-on delay
    rsi_por_timer #(
        .CYCLES (POR_CYCLES)
    ) uPor (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .restart (lvdActive),
        .holding (porHold)
    );

    // Detector pulls the shared reset line low
    assign resetLineOut  = 1'b0;
    assign resetLineOe_n = ~lvdActive;

    wire anyReset = porHold | ~resetLevel | lvdActive;

    // Sequencer
    reg [3:0] stateQ;
    reg [3:0] cntQ;

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            stateQ       <= ST_RESET;
            cntQ         <= 4'h0;
            coreReset    <= 1'b1;
            entryBusy    <= 1'b0;
            stackPush    <= 1'b0;
            stackPop     <= 1'b0;
            setMask      <= 1'b0;
            vectorAddr   <= `RSI_VEC_RESET;
            vectorLoad   <= 1'b0;
            entrySource  <= `RSI_SRC_NONE;
            extPending   <= 1'b0;
            timerPending <= 1'b0;
            optReadReq   <= 1'b0;
            optAddr      <= `RSI_OPT_ADDR;
            optionByte   <= 8'h00;
            rcOscSel     <= 1'b0;
        end else begin
            stackPush  <= 1'b0;
            stackPop   <= 1'b0;
            setMask    <= 1'b0;
            vectorLoad <= 1'b0;
            // Latch requests; a new timer edge beats the service clear, an external one does not
            if (extFall)
                extPending <= 1'b1;
            if (timerEdge)
                timerPending <= 1'b1;
            // Crystal forced while the timer pin sits at bootstrap level
            rcOscSel <= optionByte[`RSI_OPT_CLK_BIT] & ~bootSyncQ;
            if (anyReset) begin
                // Aborts any instruction or entry in progress
                stateQ       <= ST_RESET;
                coreReset    <= 1'b1;
                entryBusy    <= 1'b0;
                optReadReq   <= 1'b0;
                cntQ         <= 4'h0;
                extPending   <= 1'b0;
                timerPending <= 1'b0;
            end else begin
                case (stateQ)
                    ST_RESET: begin
                        optReadReq <= 1'b1;
                        optAddr    <= `RSI_OPT_ADDR;
                        stateQ     <= ST_OPT;
                    end
                    ST_OPT: begin
                        if (optValid) begin
                            optionByte <= optData;
                            optReadReq <= 1'b0;
                            coreReset  <= 1'b0;
                            vectorAddr <= `RSI_VEC_RESET;
                            vectorLoad <= 1'b1;
                            stateQ     <= ST_RUN;
                        end
                    end
                    ST_RUN: begin
                        if (returnExec)
                            stackPop <= 1'b1;
                        // Hardware requests only at instruction boundaries; ext before timer before trap
                        if (instrDone && !maskBit && (extPending || extFall)) begin
                            extPending  <= 1'b0;
                            entrySource <= `RSI_SRC_EXT;
                            vectorAddr  <= `RSI_VEC_EXT;
                            entryBusy   <= 1'b1;
                            cntQ        <= 4'h0;
                            stateQ      <= ST_ENTRY;
                        end else if (instrDone && !maskBit && timerPending) begin
                            timerPending <= timerEdge;
                            entrySource  <= `RSI_SRC_TIMER;
                            vectorAddr   <= `RSI_VEC_TIMER;
                            entryBusy    <= 1'b1;
                            cntQ         <= 4'h0;
                            stateQ       <= ST_ENTRY;
                        end else if (trapExec) begin
                            entrySource <= `RSI_SRC_TRAP;
                            vectorAddr  <= `RSI_VEC_TRAP;
                            entryBusy   <= 1'b1;
                            cntQ        <= 4'h0;
                            stateQ      <= ST_ENTRY;
                        end
                    end
                    ST_ENTRY: begin
                        cntQ <= cntQ + 4'h1;
                        if (cntQ == 4'h0)
                            stackPush <= 1'b1;
                        if ({28'h0, cntQ} == `RSI_ENTRY_CYC - 3)
                            setMask <= 1'b1;
                        if ({28'h0, cntQ} == `RSI_ENTRY_CYC - 2) begin
                            vectorLoad <= 1'b1;
                        end
                        if ({28'h0, cntQ} == `RSI_ENTRY_CYC - 1) begin
                            entryBusy   <= 1'b0;
                            entrySource <= `RSI_SRC_NONE;
                            stateQ      <= ST_RUN;
                        end
                    end
                    default: stateQ <= ST_RESET;
                endcase
            end
        end
    end
endmodule // rsi_reset_irq

// ===== testbench/rsi_reset_irq_props.sv
// Timing checks for the reset and interrupt sequencer
`timescale 1ns/1ps
`include "rsi_map.vh"
module rsi_reset_irq_props #(
    parameter POR_CYCLES = `RSI_POR_CYC,
    parameter HAS_LVD    = 1
) (
    // Clock and reset
    input wire        sys_clk,
    input wire        rst_n,
    // Reset side
    input wire        resetLineIn,
    input wire        resetLineOut,
    input wire        resetLineOe_n,
    input wire        lowVoltage,
    input wire        bootstrapLevel,
    input wire        rcOscSel,
    input wire [7:0]  optionByte,
    // Request side
    input wire        extReq_n,
    input wire        instrDone,
    input wire        trapExec,
    input wire        maskBit,
    input wire        coreReset,
    input wire        entryBusy,
    input wire        stackPush,
    input wire        setMask,
    input wire [10:0] vectorAddr,
    input wire        vectorLoad,
    input wire [1:0]  entrySource,
    input wire        extPending,
    input wire        timerPending
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire takeHw = instrDone && !maskBit && !entryBusy && !coreReset;
    sequence sEntry;
        ##1 stackPush ##8 setMask ##1 vectorLoad;
    endsequence
    chk_entry_steps: assert property ($rose(entryBusy) |-> sEntry)
        else $error("entry steps out of order");
    chk_ext_first: assert property (takeHw && extPending |=> entrySource == `RSI_SRC_EXT
        && vectorAddr == `RSI_VEC_EXT) else $error("external request not first");
    chk_timer_vec: assert property (takeHw && timerPending && !extPending |=>
        entrySource == `RSI_SRC_TIMER && vectorAddr == `RSI_VEC_TIMER) else $error("timer entry");
    chk_trap_any: assert property (trapExec && !entryBusy && !coreReset &&
        !(takeHw && (extPending || timerPending)) |=> entrySource == `RSI_SRC_TRAP
        && vectorAddr == `RSI_VEC_TRAP) else $error("trap entry wrong");
    chk_masked_hold: assert property (extPending && maskBit |=> extPending || coreReset)
        else $error("masked request lost");
    chk_no_abort: assert property ($rose(entryBusy) |-> $past(instrDone) || $past(trapExec))
        else $error("entry outside a boundary");
    chk_ext_edge: assert property ($fell(extReq_n) && !coreReset |->
        ##[1:4] (extPending || entryBusy || coreReset)) else $error("edge not latched");
    chk_lvd_pull: assert property ((HAS_LVD != 0 && lowVoltage) [*4] |->
        !resetLineOe_n && !resetLineOut && coreReset) else $error("line not pulled");
    chk_line_reset: assert property (!resetLineIn [*5] |-> coreReset)
        else $error("line low without reset");
    chk_por_hold: assert property ($rose(rst_n) |-> coreReset [*8])
        else $error("power-up hold short");
    // Oscillator select trails the byte load by one cycle and sees the pin two flops late
    chk_reset_exit: assert property ($fell(coreReset) |-> (vectorLoad
        && vectorAddr == `RSI_VEC_RESET)
        ##1 (rcOscSel == (optionByte[7] && !$past(bootstrapLevel, 3))))
        else $error("reset exit wrong");
endmodule // rsi_reset_irq_props
bind rsi_reset_irq rsi_reset_irq_props #(.POR_CYCLES(POR_CYCLES), .HAS_LVD(HAS_LVD))
    rsi_reset_irq_props_i (.*);

// ===== testbench/rsi_ext_model.sv
// Reset line with pull-up and option byte memory
`timescale 1ns/1ps
module rsi_ext_model #(
    parameter [7:0] OPT = 8'h8e,
    parameter       LAT = 2
) (
    input  wire        sys_clk,
    input  wire        rstCmd,
    input  wire        resetLineOut,
    input  wire        resetLineOe_n,
    output wire        resetLineIn,
    input  wire        optReadReq,
    input  wire [10:0] optAddr,
    output reg         optValid,
    output wire [7:0]  optData
);
    integer waitQ = 0;
    initial optValid = 1'b0;
    // Pull-up wins unless either party sinks the line
    assign resetLineIn = !rstCmd && (resetLineOe_n || resetLineOut);
    // Idle bus shows inverted data so a stale read cannot pass
    assign optData = (optValid && optAddr == 11'h784) ? OPT : ~OPT;
    always @(posedge sys_clk) begin
        waitQ <= optReadReq ? waitQ + 1 : 0;
        optValid <= optReadReq && waitQ >= LAT;
    end
endmodule // rsi_ext_model

// ===== testbench/test_rsi_reset_irq.sv
// Self-checking bench for the reset and interrupt sequencer
`timescale 1ns/1ps
`include "rsi_map.vh"
module test_rsi_reset_irq;
    logic sys_clk = 0, rst_n = 0, rstCmd = 0, lowVoltage = 0, bootstrapLevel = 0;
    logic extReq_n = 1, timerReq = 0, instrDone = 0, trapExec = 0, returnExec = 0, maskBit = 1;
    wire resetLineIn, resetLineOut, resetLineOe_n, optReadReq, optValid, rcOscSel, coreReset;
    wire entryBusy, stackPush, stackPop, setMask, vectorLoad, extPending, timerPending;
    wire [10:0] optAddr, vectorAddr;
    wire [7:0] optData, optionByte;
    wire [1:0] entrySource;
    int mismatches = 0, n_tests = 0;
    always #50 sys_clk = ~sys_clk;
    rsi_reset_irq #(.POR_CYCLES(8), .HAS_LVD(1)) rsi_reset_irq_i (.*);
    rsi_ext_model rsi_ext_model_i (.*);
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic cmp(string what, logic [10:0] exp, logic [10:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic waitReset(output int n);
        for (n = 0; n < 80 && coreReset !== 1'b0; n++) cyc(1);
        if (n == 80) begin
            mismatches++;
            results();
        end
        // Oscillator select follows the loaded byte one cycle later
        cyc(1);
    endtask
    task automatic take(logic trap, logic [1:0] src, logic [10:0] vec);
        int i;
        instrDone = 1;
        trapExec = trap;
        cyc(1);
        instrDone = 0;
        trapExec = 0;
        for (i = 0; i < 4 && entryBusy !== 1'b1; i++) cyc(1);
        cmp("source", src, entrySource);
        cmp("vector", vec, vectorAddr);
        for (i = 0; i < 20 && vectorLoad !== 1'b1; i++) cyc(1);
        // Vector fetch fills the last of the entry cycles
        cmp("load delay", `RSI_ENTRY_CYC - 1, i);
        for (i = 0; i < 6 && entryBusy !== 1'b0; i++) cyc(1);
        cmp("entry end", 1, i);
        cyc(1);
    endtask
    task automatic noTake;
        instrDone = 1;
        cyc(1);
        instrDone = 0;
        cyc(3);
        cmp("no entry", 0, entryBusy);
    endtask
    task automatic t_por;
        int n;
        waitReset(n);
        cmp("power-up hold", 1, n >= 8);
        cmp("option byte", 8'h8e, optionByte);
        cmp("rc select", 1, rcOscSel);
        $display("power-up test done");
    endtask
    task automatic t_line;
        int n;
        bootstrapLevel = 1;
        rstCmd = 1;
        cyc(6);
        cmp("line reset", 1, coreReset);
        rstCmd = 0;
        waitReset(n);
        cmp("forced crystal", 0, rcOscSel);
        bootstrapLevel = 0;
        $display("reset line test done");
    endtask
    task automatic t_lvd;
        int n;
        lowVoltage = 1;
        cyc(5);
        cmp("line pulled", 0, resetLineIn);
        cmp("low supply reset", 1, coreReset);
        lowVoltage = 0;
        waitReset(n);
        // Full power-on delay after recovery, then the option fetch
        cmp("power-up again", 1, n >= 12);
        $display("low supply test done");
    endtask
    task automatic t_irq;
        int i;
        extReq_n = 0;
        timerReq = 1;
        cyc(4);
        cmp("ext latched", 1, extPending);
        cmp("timer latched", 1, timerPending);
        noTake();
        cmp("ext kept", 1, extPending);
        maskBit = 0;
        cyc(3);
        cmp("waits boundary", 0, entryBusy);
        take(0, `RSI_SRC_EXT, `RSI_VEC_EXT);
        take(0, `RSI_SRC_TIMER, `RSI_VEC_TIMER);
        noTake();
        extReq_n = 1;
        cyc(3);
        extReq_n = 0;
        cyc(4);
        take(0, `RSI_SRC_EXT, `RSI_VEC_EXT);
        returnExec = 1;
        cyc(1);
        returnExec = 0;
        for (i = 0; i < 3 && stackPop !== 1'b1; i++) cyc(1);
        cmp("unstack", 1, stackPop);
        timerReq = 0;
        extReq_n = 1;
        $display("hardware request test done");
    endtask
    task automatic t_trap;
        maskBit = 1;
        cyc(2);
        timerReq = 1;
        cyc(3);
        take(1, `RSI_SRC_TRAP, `RSI_VEC_TRAP);
        cmp("timer kept", 1, timerPending);
        maskBit = 0;
        take(1, `RSI_SRC_TIMER, `RSI_VEC_TIMER);
        $display("trap test done");
    endtask
    initial begin
        cyc(8);
        rst_n = 1;
        t_por();
        t_line();
        t_lvd();
        t_irq();
        t_trap();
        results();
    end
    initial begin
        cyc(20000);
        mismatches++;
        results();
    end
endmodule // test_rsi_reset_irq
